/* rtl/sifo_regs.vh */
// register offsets, field layouts, reset values and timing counts of the input filter block
`ifndef SIFO_REGS_VH
`define SIFO_REGS_VH

// register word addresses on the plain port
`define SIFO_ADDR_W 4
`define SIFO_OFF_TIME_CODE 4'h0
`define SIFO_OFF_FILT_EN 4'h1
`define SIFO_OFF_INV_MASK 4'h2
`define SIFO_OFF_FIX_SEL 4'h3
`define SIFO_OFF_FIX_VAL 4'h4
`define SIFO_OFF_CTRL 4'h5
`define SIFO_OFF_IN_STATUS 4'h6
`define SIFO_OFF_OUT_STATUS 4'h7

// control register fields
`define SIFO_CTRL_INV_ALL 0
`define SIFO_CTRL_PIN_FILT 1
`define SIFO_CTRL_PAR_MUX 2

// reset values
`define SIFO_RST_TIME_CODE 3'h0
`define SIFO_RST_FILT_EN 4'h0
`define SIFO_RST_INV_MASK 4'h0
`define SIFO_RST_FIX_SEL 4'h0
`define SIFO_RST_FIX_VAL 4'h0
`define SIFO_RST_CTRL 3'h0

// time codes
`define SIFO_CODE_BUS_CYCLE 3'h7

// timing: base time in ns, clock period in ns, tolerance -1/16 (6.25 percent)
`define SIFO_CLK_PERIOD_NS 10
`define SIFO_BASE_TIME_NS 128000
`define SIFO_BLOCK_TIME_NS 256000
// least times round up; tolerance lets the count shrink by 1/16
`define SIFO_BASE_CYCLES ((`SIFO_BASE_TIME_NS * 15 / 16 + `SIFO_CLK_PERIOD_NS - 1) / `SIFO_CLK_PERIOD_NS)
`define SIFO_BLOCK_CYCLES ((`SIFO_BLOCK_TIME_NS * 15 / 16 + `SIFO_CLK_PERIOD_NS - 1) / `SIFO_CLK_PERIOD_NS)
`define SIFO_TMR_W 20

`endif

/* rtl/sifo_debounce.v */
// one channel of the time-constant debounce filter
`timescale 1ns/1ns
module sifo_debounce (
   // clock and reset
   input wire core_clk_in,
   input wire rstn_in,
   // raw level and settle limit
   input wire raw_in,
   input wire [19:0] limit_in,
   // filtered level
   output wire filt_out
);
   reg cand_reg;
   reg filt_reg;
   reg [19:0] tmr_reg;

   assign filt_out = filt_reg;

   // candidate tracks the pin; timer restarts on every disagreement
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         cand_reg <= 1'b0;
         filt_reg <= 1'b0;
         tmr_reg <= 20'h00000;
      end else if (raw_in != cand_reg) begin
         cand_reg <= raw_in;
         tmr_reg <= 20'h00000;
      end else if (tmr_reg >= limit_in) begin
         filt_reg <= cand_reg;
      end else begin
         tmr_reg <= tmr_reg + 20'h00001;
      end
   end
endmodule

/* rtl/sifo_top.v */
// input debounce, inversion, bus-cycle confirmation and fixed output override
//
// Design decisions made here: strobed register access and the register offsets.
`timescale 1ns/1ns
`include "sifo_regs.vh"

module sifo_top (
   // clock and reset
   input wire core_clk_in,
   input wire rstn_in,
   // register port
   input wire [3:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   output wire [7:0] reg_rdata_out,
   // input pins and parameter pin one
   input wire [3:0] data_in_pins_in,
   input wire parameter_pin_one_in,
   // exchange events from the slave logic
   input wire exch_sample_in,
   input wire exch_out_valid_in,
   input wire [3:0] exch_out_data_in,
   // answer data and output pins
   output wire [3:0] slave_resp_data_out,
   output wire [3:0] data_out_od_out,
   output wire [3:0] data_out_oen_out,
   output wire par_one_mux_excl_out
);
   // configuration registers
   reg [2:0] input_filter_time_code_reg;
   reg [3:0] input_filter_enable_mask_reg;
   reg [3:0] per_channel_invert_mask_reg;
   reg [3:0] fixed_output_select_mask_reg;
   reg [3:0] fixed_output_value_reg;
   reg [2:0] ctrl_reg;
   reg [7:0] rdata_reg;
   // pin synchronisers
   reg [3:0] din_s1_reg;
   reg [3:0] din_s2_reg;
   reg [3:0] din_s3_reg;
   reg [3:0] din_stable_reg;
   reg p1_s1_reg;
   reg p1_s2_reg;
   reg p1_s3_reg;
   reg p1_stable_reg;
   // bus-cycle filter state
   localparam ST_IDLE = 2'b01;
   localparam ST_BLOCK = 2'b10;
   reg [1:0] bc_state_reg;
   reg [1:0] bc_state_next;
   reg [19:0] bc_tmr_reg;
   reg [19:0] bc_tmr_next;
   reg [3:0] bc_last_reg;
   reg [3:0] bc_last_next;
   reg [3:0] bc_valid_reg;
   reg [3:0] bc_valid_next;
   // outputs
   reg [3:0] resp_reg;
   reg [3:0] dout_data_reg;
   reg [3:0] od_reg;
   reg [3:0] oen_reg;
   reg excl_reg;

   // sampling edge of the exchange event
   reg samp_prev_reg;
   // per-channel select results
   reg [3:0] resp_next;
   reg [3:0] drive_val;
   integer k;

   // combinational paths
   wire [3:0] inv_data;
   wire [3:0] time_filt;
   wire [3:0] filt_sel;
   wire sample_match;
   wire [19:0] time_limit;
   wire [31:0] block_full;
   wire [19:0] block_last;
   wire inv_all;
   wire pin_filt_flag;
   wire par_mux_cfg;
   wire bus_cycle_mode;
   wire filters_off;
   wire samp_edge;
   wire sample_ok;

   // settle count for a time code: base count doubled per step; the
   // bus-cycle code would overflow the timer, so it gets the top count
   function [19:0] sifo_limit;
      input [2:0] code;
      reg [31:0] full;
      reg [19:0] base;
      begin
         full = `SIFO_BASE_CYCLES;
         base = full[19:0];
         case (code)
            3'h0: sifo_limit = base - 20'h00001;
            3'h1: sifo_limit = (base << 1) - 20'h00001;
            3'h2: sifo_limit = (base << 2) - 20'h00001;
            3'h3: sifo_limit = (base << 3) - 20'h00001;
            3'h4: sifo_limit = (base << 4) - 20'h00001;
            3'h5: sifo_limit = (base << 5) - 20'h00001;
            3'h6: sifo_limit = (base << 6) - 20'h00001;
            default: sifo_limit = 20'hfffff;
         endcase
      end
   endfunction

   assign time_limit = sifo_limit(input_filter_time_code_reg);
   assign bus_cycle_mode = (input_filter_time_code_reg == `SIFO_CODE_BUS_CYCLE);

   // last count of the blocking window, cut to the timer width on purpose
   assign block_full = `SIFO_BLOCK_CYCLES - 32'h00000001;
   assign block_last = block_full[19:0];

   // control fields by name
   assign inv_all = ctrl_reg[`SIFO_CTRL_INV_ALL];
   assign pin_filt_flag = ctrl_reg[`SIFO_CTRL_PIN_FILT];
   assign par_mux_cfg = ctrl_reg[`SIFO_CTRL_PAR_MUX];

   // register writes
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         input_filter_time_code_reg <= `SIFO_RST_TIME_CODE;
         input_filter_enable_mask_reg <= `SIFO_RST_FILT_EN;
         per_channel_invert_mask_reg <= `SIFO_RST_INV_MASK;
         fixed_output_select_mask_reg <= `SIFO_RST_FIX_SEL;
         fixed_output_value_reg <= `SIFO_RST_FIX_VAL;
         ctrl_reg <= `SIFO_RST_CTRL;
      end else if (reg_wr_in) begin
         case (reg_addr_in)
            `SIFO_OFF_TIME_CODE: input_filter_time_code_reg <= reg_wdata_in[2:0];
            `SIFO_OFF_FILT_EN: input_filter_enable_mask_reg <= reg_wdata_in[3:0];
            `SIFO_OFF_INV_MASK: per_channel_invert_mask_reg <= reg_wdata_in[3:0];
            `SIFO_OFF_FIX_SEL: fixed_output_select_mask_reg <= reg_wdata_in[3:0];
            `SIFO_OFF_FIX_VAL: fixed_output_value_reg <= reg_wdata_in[3:0];
            `SIFO_OFF_CTRL: ctrl_reg <= reg_wdata_in[2:0];
            default: ctrl_reg <= ctrl_reg; // unmapped writes are dropped
         endcase
      end
   end

   // register reads, data valid the cycle after the strobe; unmapped reads zero
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         rdata_reg <= 8'h00;
      end else if (reg_rd_in) begin
         case (reg_addr_in)
            `SIFO_OFF_TIME_CODE: rdata_reg <= {5'h00, input_filter_time_code_reg};
            `SIFO_OFF_FILT_EN: rdata_reg <= {4'h0, input_filter_enable_mask_reg};
            `SIFO_OFF_INV_MASK: rdata_reg <= {4'h0, per_channel_invert_mask_reg};
            `SIFO_OFF_FIX_SEL: rdata_reg <= {4'h0, fixed_output_select_mask_reg};
            `SIFO_OFF_FIX_VAL: rdata_reg <= {4'h0, fixed_output_value_reg};
            `SIFO_OFF_CTRL: rdata_reg <= {5'h00, ctrl_reg};
            `SIFO_OFF_IN_STATUS: rdata_reg <= {din_stable_reg, resp_reg};
            `SIFO_OFF_OUT_STATUS: rdata_reg <= {oen_reg, dout_data_reg};
            default: rdata_reg <= 8'h00;
         endcase
      end else begin
         rdata_reg <= 8'h00;
      end
   end

   // three-stage pin sync; a level counts once stages two and three agree
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         din_s1_reg <= 4'h0;
         din_s2_reg <= 4'h0;
         din_s3_reg <= 4'h0;
         din_stable_reg <= 4'h0;
      end else begin
         din_s1_reg <= data_in_pins_in;
         din_s2_reg <= din_s1_reg;
         din_s3_reg <= din_s2_reg;
         din_stable_reg <= (din_s2_reg & din_s3_reg) | (din_stable_reg & (din_s2_reg | din_s3_reg));
      end
   end

   // pin one the same way; the filter flag reads only the agreed level
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         p1_s1_reg <= 1'b0;
         p1_s2_reg <= 1'b0;
         p1_s3_reg <= 1'b0;
         p1_stable_reg <= 1'b0;
      end else begin
         p1_s1_reg <= parameter_pin_one_in;
         p1_s2_reg <= p1_s1_reg;
         p1_s3_reg <= p1_s2_reg;
         if (p1_s2_reg == p1_s3_reg) begin
            p1_stable_reg <= p1_s3_reg;
         end
      end
   end

   // global invert overrides the mask; inversion sits ahead of filtering
   assign inv_data = inv_all ? ~din_stable_reg
      : din_stable_reg ^ per_channel_invert_mask_reg;

   // time-constant filters always run, whatever the mode
   genvar ch;
   generate
      for (ch = 0; ch < 4; ch = ch + 1) begin : g_ch
         sifo_debounce u_deb (
            .core_clk_in(core_clk_in),
            .rstn_in(rstn_in),
            .raw_in(inv_data[ch]),
            .limit_in(time_limit),
            .filt_out(time_filt[ch])
         );
      end
   endgenerate

   // a held event line counts once; otherwise it would resample after the window
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         samp_prev_reg <= 1'b0;
      end else begin
         samp_prev_reg <= exch_sample_in;
      end
   end
   assign samp_edge = exch_sample_in & ~samp_prev_reg;

   // bus-cycle confirmation: two equal samples, then a blocking window
   assign sample_ok = samp_edge && (bc_state_reg == ST_IDLE);
   assign sample_match = (inv_data == bc_last_reg);
   always @* begin
      bc_state_next = bc_state_reg;
      bc_tmr_next = bc_tmr_reg;
      bc_last_next = bc_last_reg;
      bc_valid_next = bc_valid_reg;
      case (bc_state_reg)
         ST_IDLE: begin
            if (sample_ok) begin
               bc_last_next = inv_data;
               bc_valid_next = sample_match ? inv_data : bc_valid_reg;
               bc_state_next = ST_BLOCK;
               bc_tmr_next = 20'h00000;
            end
         end
         ST_BLOCK: begin
            // repeated requests in this window cannot validate data
            if (bc_tmr_reg >= block_last) begin
               bc_state_next = ST_IDLE;
            end else begin
               bc_tmr_next = bc_tmr_reg + 20'h00001;
            end
         end
         default: bc_state_next = ST_IDLE;
      endcase
   end

   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         bc_state_reg <= ST_IDLE;
         bc_tmr_reg <= 20'h00000;
         bc_last_reg <= 4'h0;
         bc_valid_reg <= 4'h0;
      end else begin
         bc_state_reg <= bc_state_next;
         bc_tmr_reg <= bc_tmr_next;
         bc_last_reg <= bc_last_next;
         bc_valid_reg <= bc_valid_next;
      end
   end

   // pin one high bypasses filters only when the pin flag is set
   assign filters_off = pin_filt_flag & p1_stable_reg;
   assign filt_sel = bus_cycle_mode ? bc_valid_reg : time_filt;

   // per channel: bit k of every mask serves input and output channel k
   always @* begin
      resp_next = 4'h0;
      drive_val = 4'h0;
      for (k = 0; k < 4; k = k + 1) begin
         if (filters_off) begin
            resp_next[k] = inv_data[k];
         end else if (input_filter_enable_mask_reg[k]) begin
            resp_next[k] = filt_sel[k];
         end else begin
            resp_next[k] = inv_data[k];
         end
         // fixed value replaces exchange data, same index in both masks
         if (fixed_output_select_mask_reg[k]) begin
            drive_val[k] = fixed_output_value_reg[k];
         end else begin
            drive_val[k] = dout_data_reg[k];
         end
      end
   end

   // answer data; filters start from zero after reset
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         resp_reg <= 4'h0;
      end else begin
         resp_reg <= resp_next;
      end
   end

   // exchange data latch; reset leaves every output released
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         dout_data_reg <= 4'hf;
      end else if (exch_out_valid_in) begin
         dout_data_reg <= exch_out_data_in;
      end
   end

   // output pins; open drain pulls low for a zero, released otherwise
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         od_reg <= 4'h0;
         oen_reg <= 4'hf;
      end else begin
         od_reg <= 4'h0;
         oen_reg <= drive_val; // low enable drives the low level
      end
   end

   // keep pin one out of multiplexing while it steers the filters
   always @(posedge core_clk_in) begin
      if (!rstn_in) begin
         excl_reg <= 1'b0;
      end else begin
         excl_reg <= pin_filt_flag & par_mux_cfg;
      end
   end

   assign reg_rdata_out = rdata_reg;
   assign slave_resp_data_out = resp_reg;
   assign data_out_od_out = od_reg;
   assign data_out_oen_out = oen_reg;
   assign par_one_mux_excl_out = excl_reg;
endmodule

/* bench/sifo_checker.sv */
// port assertions for the input filter and fixed output block
`timescale 1ns/1ns
module sifo_checker (
   // clock and register port
   input wire core_clk_in,
   input wire rstn_in,
   input wire [3:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire reg_wr_in,
   input wire reg_rd_in,
   input wire [7:0] reg_rdata_out,
   // exchange and pins
   input wire exch_sample_in,
   input wire exch_out_valid_in,
   input wire [3:0] slave_resp_data_out,
   input wire [3:0] data_out_od_out,
   input wire [3:0] data_out_oen_out,
   input wire par_one_mux_excl_out
);
   default clocking @(posedge core_clk_in); endclocking
   default disable iff (!rstn_in);
   // open drain only ever pulls low
   od_low_a: assert property (data_out_od_out == 4'h0)
      else $error("open drain value not zero");
   // read data stands one cycle only
   rd_idle_a: assert property (!reg_rd_in |=> reg_rdata_out == 8'h00)
      else $error("read data without read");
   unmapped_rd_a: assert property (reg_rd_in && reg_addr_in[3] |=> reg_rdata_out == 8'h00)
      else $error("unmapped read not zero");
   in_status_a: assert property (reg_rd_in && reg_addr_in == 4'h6
      |=> reg_rdata_out[3:0] == $past(slave_resp_data_out))
      else $error("input status differs from answer data");
   out_status_a: assert property (reg_rd_in && reg_addr_in == 4'h7
      |=> reg_rdata_out[7:4] == $past(data_out_oen_out))
      else $error("output status differs from pins");
   // exclusion needs both flag and multiplex bit
   excl_set_a: assert property (reg_wr_in && reg_addr_in == 4'h5
      && reg_wdata_in[2:1] == 2'b11 |=> ##[0:1] par_one_mux_excl_out)
      else $error("pin one not excluded");
   excl_clr_a: assert property (reg_wr_in && reg_addr_in == 4'h5
      && reg_wdata_in[2:1] != 2'b11 |=> ##1 !par_one_mux_excl_out)
      else $error("pin one excluded without cause");
   rst_vals_a: assert property ($rose(rstn_in) |->
      slave_resp_data_out == 4'h0 && data_out_oen_out == 4'hf)
      else $error("wrong values after reset");
   // output enables move only after exchange data or a register write; the latch
   // and the pin stage put two edges between cause and visible change
   oen_cause_a: assert property ($changed(data_out_oen_out)
      |-> $past(exch_out_valid_in, 2) || $past(reg_wr_in, 2))
      else $error("output changed without cause");
   cover property (reg_rd_in && reg_addr_in == 4'h6);
   cover property (exch_sample_in);
   cover property (par_one_mux_excl_out);
endmodule
bind sifo_top sifo_checker sifo_checker_i (.core_clk_in, .rstn_in, .reg_addr_in,
   .reg_wdata_in, .reg_wr_in, .reg_rd_in, .reg_rdata_out, .exch_sample_in,
   .exch_out_valid_in, .slave_resp_data_out, .data_out_od_out, .data_out_oen_out,
   .par_one_mux_excl_out);

/* bench/sifo_master_model.sv */
// polling master model: sampling events and output data
`timescale 1ns/1ns
module sifo_master_model (
   // clock
   input wire core_clk_in,
   // exchange events
   output reg samp_out = 1'b0,
   output reg valid_out = 1'b0,
   output reg [3:0] data_out = 4'h0
);
   // data inverted once invalid so stale data never passes
   task exchange(input [3:0] d);
      begin
         @(posedge core_clk_in);
         data_out <= d;
         valid_out <= 1'b1;
         @(posedge core_clk_in);
         valid_out <= 1'b0;
         data_out <= ~d;
      end
   endtask
   // one input sampling event
   task sample;
      begin
         @(posedge core_clk_in);
         samp_out <= 1'b1;
         @(posedge core_clk_in);
         samp_out <= 1'b0;
      end
   endtask
endmodule

/* bench/testbench.sv */
// self-checking bench for the input filter and fixed output block
`timescale 1ns/1ns
module testbench;
   reg core_clk_in = 1'b0;
   reg rstn_in = 1'b0;
   reg [3:0] addr = 4'h0;
   reg [7:0] wdata = 8'h00;
   reg wr_s = 1'b0;
   reg rd_s = 1'b0;
   reg [3:0] pins = 4'h0;
   reg pin_one = 1'b0;
   reg [7:0] rv;
   wire [7:0] rdata;
   wire [3:0] resp, oen, xdata;
   wire excl, samp, xvalid;
   integer failures = 0;
   integer check_count = 0;
   integer i;
   always #5 core_clk_in = ~core_clk_in;
   sifo_top sifo_top_i (.core_clk_in(core_clk_in), .rstn_in(rstn_in), .reg_addr_in(addr),
      .reg_wdata_in(wdata), .reg_wr_in(wr_s), .reg_rd_in(rd_s), .reg_rdata_out(rdata),
      .data_in_pins_in(pins), .parameter_pin_one_in(pin_one), .exch_sample_in(samp),
      .exch_out_valid_in(xvalid), .exch_out_data_in(xdata), .slave_resp_data_out(resp),
      .data_out_od_out(), .data_out_oen_out(oen), .par_one_mux_excl_out(excl));
   sifo_master_model m (.core_clk_in(core_clk_in), .samp_out(samp), .valid_out(xvalid),
      .data_out(xdata));
   task chk(input [7:0] seen, input [7:0] exp);
      begin
         check_count = check_count + 1;
         if (seen !== exp) begin
            failures = failures + 1;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task wr(input [3:0] a, input [7:0] d);
      begin
         @(posedge core_clk_in);
         addr <= a;
         wdata <= d;
         wr_s <= 1'b1;
         @(posedge core_clk_in);
         wr_s <= 1'b0;
      end
   endtask
   // read data is caught in the one cycle it stands
   task rd(input [3:0] a);
      begin
         @(posedge core_clk_in);
         addr <= a;
         rd_s <= 1'b1;
         @(posedge core_clk_in);
         rd_s <= 1'b0;
         #1 rv = rdata;
      end
   endtask
   task pause(input integer n);
      begin
         repeat (n) @(posedge core_clk_in);
         #1;
      end
   endtask
   task s_out;
      begin
         for (i = 0; i < 6; i = i + 1) begin
            rd(i[3:0]);
            chk(rv, 8'h00);
         end
         rd(4'h9);
         chk(rv, 8'h00);
         m.exchange(4'h5);
         pause(2);
         chk(oen, 4'h5);
         wr(4'h4, 8'h02);
         wr(4'h3, 8'h06);
         pause(2);
         chk(oen, 4'h3);
         m.exchange(4'ha);
         pause(2);
         chk(oen, 4'ha);
         rd(4'h7);
         chk(rv, 8'haa);
      end
   endtask
   task s_raw;
      begin
         @(posedge core_clk_in) pins <= 4'h3;
         pause(10);
         chk(resp, 4'h3);
         wr(4'h2, 8'h01);
         pause(10);
         chk(resp, 4'h2);
         wr(4'h5, 8'h01);
         pause(10);
         chk(resp, 4'hc);
         rd(4'h6);
         chk(rv, 8'h3c);
         wr(4'h5, 8'h00);
         wr(4'h2, 8'h00);
      end
   endtask
   // a short glitch must restart the settle time
   task s_filt;
      begin
         wr(4'h1, 8'h0f);
         @(posedge core_clk_in) pins <= 4'h9;
         pause(6000);
         @(posedge core_clk_in) pins <= 4'h0;
         pause(3);
         @(posedge core_clk_in) pins <= 4'h9;
         pause(11000);
         chk(resp, 4'h0);
         pause(1100);
         chk(resp, 4'h9);
         wr(4'h5, 8'h06);
         @(posedge core_clk_in) pins <= 4'h6;
         pin_one <= 1'b1;
         pause(10);
         chk(resp, 4'h6);
         chk(excl, 1'b1);
         @(posedge core_clk_in) pin_one <= 1'b0;
         pause(10);
         chk(resp, 4'h9);
         wr(4'h5, 8'h00);
      end
   endtask
   // time code one doubles the settle time: old level holds past the base time
   task s_code;
      begin
         wr(4'h0, 8'h01);
         @(posedge core_clk_in) pins <= 4'h3;
         pause(13000);
         chk(resp, 4'h9);
         pause(11200);
         chk(resp, 4'h3);
      end
   endtask
   // repeated samples inside the blocking time count for nothing
   task s_bus;
      begin
         wr(4'h0, 8'h07);
         @(posedge core_clk_in) pins <= 4'h5;
         pause(10);
         m.sample;
         pause(5);
         chk(resp == 4'h5, 1'b0);
         pause(24010);
         m.sample;
         pause(5);
         chk(resp, 4'h5);
         @(posedge core_clk_in) pins <= 4'ha;
         pause(10);
         m.sample;
         m.sample;
         pause(5);
         chk(resp, 4'h5);
      end
   endtask
   task end_sim;
      begin
         $display("checks %0d failures %0d", check_count, failures);
         if (failures == 0 && check_count > 0)
            $display("STATUS OK");
         else
            $display("STATUS NOT OK");
         $finish;
      end
   endtask
   initial begin
      repeat (12) @(posedge core_clk_in);
      rstn_in <= 1'b1;
      s_out;
      s_raw;
      s_filt;
      s_code;
      s_bus;
      end_sim;
   end
   // hang guard
   initial begin
      #900000;
      failures = failures + 1;
      end_sim;
   end
endmodule
